// >>> fhri_defs.vh
// constants for the floppy host register interface
// assumes a single 200 MHz mclk standing in for the 24 MHz oscillator
`ifndef FHRI_DEFS_VH
`define FHRI_DEFS_VH

// host address decode, three lines
`define FHRI_ADDR_DRIVE_CTRL 3'h2
`define FHRI_ADDR_STATUS 3'h4
`define FHRI_ADDR_DATA 3'h5
`define FHRI_ADDR_RATE_MEDIA 3'h7

// drive control fields
`define FHRI_DCR_MOTOR_HI 7
`define FHRI_DCR_MOTOR_LO 4
`define FHRI_DCR_DMA_EN 3
`define FHRI_DCR_SOFT_RST 2
`define FHRI_DCR_RESET 8'h00

// rate select codes
`define FHRI_RATE_500 2'h0
`define FHRI_RATE_300 2'h1
`define FHRI_RATE_250 2'h2
`define FHRI_RATE_1000 2'h3
`define FHRI_RATE_RESET 2'h2

// prescaler divide factors
`define FHRI_DIV_8M 3'h3
`define FHRI_DIV_4M8 3'h5
`define FHRI_DIV_4M 3'h6

// precompensation select codes
`define FHRI_PRE_83NS 2'h0
`define FHRI_PRE_125NS 2'h1
`define FHRI_PRE_208NS 2'h2
`define FHRI_PRE_250NS 2'h3

// status bit positions
`define FHRI_MSR_RQM 7
`define FHRI_MSR_DIO 6
`define FHRI_MSR_NDMA 5
`define FHRI_MSR_CIP 4

// timing
`define FHRI_CLK_MHZ 200
`define FHRI_AUTO_LP_MS 500
`define FHRI_AUTO_LP_CYC (`FHRI_AUTO_LP_MS * `FHRI_CLK_MHZ * 1000)
`define FHRI_OSC_STAB_MS 2
`define FHRI_OSC_STAB_CYC (`FHRI_OSC_STAB_MS * `FHRI_CLK_MHZ * 1000)

`endif

// >>> fhri_top.v
// floppy host register interface: bus decode, rate/precomp, drive control,
// main status handshake, disk changed, low power and the first result byte
// assumes host strobes and core handshakes are synchronous to mclk
`timescale 1ns/1ps
`include "fhri_defs.vh"

// Operation
// [R1] core clock tick divides input by 3, 5 or 6 per rate
// [R2] 300 kb/s setting uses 4.8 MHz if drive type high, else 4 MHz
// [R3] rate field picks 500/250-300/250/1000 plus filter ground and speed pin
// [R4] precomp 125 ns, 83 at 1000, 208 at 300; pin high gives 250 at 250
// [R5] hardware reset loads rate field with 10, 250 kb/s
// [R6] low power stops oscillator and core; core logic idle until wake-up
// [R7] any status or data register access wakes the oscillator
// [R8] request-for-master held low while oscillator stabilises
// [R9] low power entered on command or after idle timeout
// [R10] rate and drive control registers and outputs stay live in low power
// [R11] drive select asserted only when encoded and its motor bit set
// [R12] motor bits 7..4 drive motor outputs low when set
// [R13] dma enable bit gates dma request, acknowledge and interrupt
// [R14] soft reset bit low holds core reset; registers unchanged
// [R15] status register always readable with no delay
// [R16] request-for-master clears on byte transfer, sets when core ready
// [R17] direction bit: 0 host writes, 1 host reads
// [R18] non-dma execution bit set only in non-dma execution phase
// [R19] busy bit set on first command byte, cleared at command end
// [R20] seeking bits set at seek start, cleared on sense interrupt read
// [R21] disk changed read drives bit 7 inverse input, others undriven
// [R22] first result byte carries two-bit termination code on top
// [R23] hardware reset clears drive control; core reset until bit written
// [R24] dma enable low floats interrupt and dma request, ignores acknowledge
// [R25] decode 2,4,5,7; other addresses leave the bus undriven
module fhri_top #(
  parameter AUTO_LP_CYCLES = `FHRI_AUTO_LP_CYC,
  parameter OSC_STAB_CYCLES = `FHRI_OSC_STAB_CYC
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // host bus
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire [2:0] addr,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg [7:0] data_oe_n,
  // dma and interrupt pins
  output reg int_out,
  output reg int_oe_n,
  output reg dma_request,
  output reg dma_request_oe_n,
  input wire dma_acknowledge_n,
  // drive pins
  input wire drive_type_pin,
  input wire precomp_mode_pin,
  input wire disk_changed_input,
  output reg [3:0] motor_out_n,
  output reg [3:0] drive_select_n,
  output reg filter_ground_high_rate,
  output reg filter_ground_low_rate,
  output reg spindle_speed_low_current,
  // clock and power control
  output reg core_tick,
  output reg [1:0] precomp_sel,
  output reg osc_on,
  output reg core_reset,
  // controller core handshake
  input wire core_byte_ready,
  input wire core_dir_read,
  input wire core_exec_nondma,
  input wire core_cmd_done,
  input wire core_seek_set,
  input wire core_seek_clr,
  input wire [1:0] core_seek_drive,
  input wire [7:0] core_result_byte,
  input wire core_int_req,
  input wire core_dma_req,
  input wire core_lp_now,
  input wire core_lp_auto_en,
  input wire core_idle,
  input wire [1:0] res_term_code,
  input wire [5:0] res_low_bits,
  output reg [7:0] cmd_byte,
  output reg cmd_byte_strobe,
  output reg result_read_strobe,
  output reg dma_ack_core,
  output reg [7:0] result_status_zero
);

  localparam [2:0] PWR_ON = 3'h1;
  localparam [2:0] PWR_OFF = 3'h2;
  localparam [2:0] PWR_STAB = 3'h4;

  // divide factor for the core clock
  function [2:0] div_of;
    input [1:0] rate;
    input dtype;
    begin
      case (rate)
        `FHRI_RATE_500: div_of = `FHRI_DIV_8M;
        `FHRI_RATE_300: div_of = dtype ? `FHRI_DIV_4M8 : `FHRI_DIV_4M; // [R2]
        `FHRI_RATE_250: div_of = `FHRI_DIV_4M;
        default: div_of = `FHRI_DIV_8M;
      endcase
    end
  endfunction

  // precompensation select
  function [1:0] pre_of;
    input [1:0] rate;
    input dtype;
    input alt;
    begin
      case (rate)
        `FHRI_RATE_1000: pre_of = `FHRI_PRE_83NS;
        `FHRI_RATE_500: pre_of = `FHRI_PRE_125NS;
        `FHRI_RATE_300: begin
          if (dtype)
            pre_of = `FHRI_PRE_208NS;
          else
            pre_of = alt ? `FHRI_PRE_250NS : `FHRI_PRE_125NS;
        end
        default: pre_of = alt ? `FHRI_PRE_250NS : `FHRI_PRE_125NS;
      endcase
    end
  endfunction

  reg [7:0] dcr_r;
  reg [1:0] rate_r;
  reg [2:0] div_cnt_r;
  reg rqm_r;
  reg cip_r;
  reg [3:0] seek_r;
  reg dkr_r;
  reg rd_q_r;
  reg wr_q_r;
  reg [2:0] pwr_r;
  reg [2:0] pwr_nxt;
  reg [31:0] lp_cnt_r;
  reg [31:0] stab_cnt_r;

  wire sel = ~cs_n;
  wire rd_act = sel & ~rd_n;
  wire wr_act = sel & ~wr_n;
  wire rd_start = rd_act & ~rd_q_r;
  wire wr_start = wr_act & ~wr_q_r;
  wire msr_hit = (addr == `FHRI_ADDR_STATUS);
  wire dr_hit = (addr == `FHRI_ADDR_DATA);
  wire wake_acc = (rd_start | wr_start) & (msr_hit | dr_hit);
  wire run = pwr_r[0];
  wire dma_en = dcr_r[`FHRI_DCR_DMA_EN];
  wire dr_wr = wr_start & dr_hit & run & rqm_r & ~core_reset;
  wire dr_rd = rd_start & dr_hit & run & rqm_r & ~core_reset;
  wire [2:0] div_n = div_of(rate_r, drive_type_pin);
  wire [3:0] motor_on = dcr_r[`FHRI_DCR_MOTOR_HI:`FHRI_DCR_MOTOR_LO];
  wire [7:0] msr_val = {rqm_r & run, core_dir_read, core_exec_nondma, cip_r, seek_r};

  always @(posedge mclk) begin
    rd_q_r <= rd_act;
    wr_q_r <= wr_act;
  end

  // host register writes
  always @(posedge mclk) begin
    if (rst) begin
      dcr_r <= `FHRI_DCR_RESET; // [R23]
      rate_r <= `FHRI_RATE_RESET; // [R5]
    end else if (wr_start) begin
      if (addr == `FHRI_ADDR_DRIVE_CTRL)
        dcr_r <= data_in;
      if (addr == `FHRI_ADDR_RATE_MEDIA)
        rate_r <= data_in[1:0];
    end
  end

  // power state, registers above are untouched by it [R10]
  always @* begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PWR_ON: begin
        if (core_lp_now | (core_lp_auto_en & (lp_cnt_r == AUTO_LP_CYCLES - 1))) // [R9]
          pwr_nxt = PWR_OFF;
      end
      PWR_OFF: begin
        if (wake_acc) // [R7]
          pwr_nxt = PWR_STAB;
      end
      PWR_STAB: begin
        if (stab_cnt_r == OSC_STAB_CYCLES - 1)
          pwr_nxt = PWR_ON;
      end
      default: pwr_nxt = PWR_ON;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      pwr_r <= PWR_ON;
      lp_cnt_r <= 32'h0;
      stab_cnt_r <= 32'h0;
    end else begin
      pwr_r <= pwr_nxt;
      if (run & core_idle & core_lp_auto_en)
        lp_cnt_r <= lp_cnt_r + 32'h1;
      else
        lp_cnt_r <= 32'h0;
      if (pwr_r == PWR_STAB)
        stab_cnt_r <= stab_cnt_r + 32'h1;
      else
        stab_cnt_r <= 32'h0;
    end
  end

  // core clock prescaler, held at zero while the oscillator is off or stabilising
  always @(posedge mclk) begin
    if (rst) begin
      div_cnt_r <= 3'h0;
      core_tick <= 1'b0;
    end else if (!run) begin
      div_cnt_r <= 3'h0; // [R6]
      core_tick <= 1'b0;
    end else if (div_cnt_r >= div_n - 3'h1) begin
      div_cnt_r <= 3'h0; // [R1]
      core_tick <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 3'h1;
      core_tick <= 1'b0;
    end
  end

  // main status handshake, core events win over host clears
  always @(posedge mclk) begin
    if (rst | core_reset) begin
      rqm_r <= 1'b0;
      cip_r <= 1'b0;
      seek_r <= 4'h0;
    end else begin
      if (core_byte_ready)
        rqm_r <= 1'b1; // [R16]
      else if (dr_wr | dr_rd)
        rqm_r <= 1'b0; // [R16]
      if (dr_wr & ~cip_r)
        cip_r <= 1'b1; // [R19]
      else if (core_cmd_done)
        cip_r <= 1'b0; // [R19]
      if (core_seek_set)
        seek_r[core_seek_drive] <= 1'b1; // [R20]
      else if (core_seek_clr)
        seek_r[core_seek_drive] <= 1'b0; // [R20]
    end
  end

  // host read data and bus drive
  always @(posedge mclk) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe_n <= 8'hff;
      dkr_r <= 1'b0;
    end else begin
      dkr_r <= ~disk_changed_input; // [R21]
      data_out <= 8'h00;
      data_oe_n <= 8'hff; // [R25]
      if (rd_act) begin
        case (addr)
          `FHRI_ADDR_STATUS: begin
            data_out <= msr_val; // [R15] [R8] [R17] [R18]
            data_oe_n <= 8'h00;
          end
          `FHRI_ADDR_DATA: begin
            data_out <= core_result_byte;
            data_oe_n <= 8'h00;
          end
          `FHRI_ADDR_RATE_MEDIA: begin
            data_out <= {dkr_r, 7'h00};
            data_oe_n <= 8'h7f; // [R21]
          end
          default: begin
            data_out <= 8'h00;
            data_oe_n <= 8'hff;
          end
        endcase
      end
    end
  end

  // strobes to the core
  always @(posedge mclk) begin
    if (rst) begin
      cmd_byte <= 8'h00;
      cmd_byte_strobe <= 1'b0;
      result_read_strobe <= 1'b0;
    end else begin
      cmd_byte_strobe <= dr_wr;
      result_read_strobe <= dr_rd;
      if (dr_wr)
        cmd_byte <= data_in;
    end
  end

  // drive, rate and gating outputs
  always @(posedge mclk) begin
    if (rst) begin
      motor_out_n <= 4'hf;
      drive_select_n <= 4'hf;
      filter_ground_high_rate <= 1'b0;
      filter_ground_low_rate <= 1'b0;
      spindle_speed_low_current <= 1'b0;
      precomp_sel <= `FHRI_PRE_125NS;
      osc_on <= 1'b1;
      core_reset <= 1'b1;
      int_out <= 1'b0;
      int_oe_n <= 1'b1;
      dma_request <= 1'b0;
      dma_request_oe_n <= 1'b1;
      dma_ack_core <= 1'b0;
      result_status_zero <= 8'h00;
    end else begin
      motor_out_n <= ~motor_on; // [R12]
      drive_select_n <= 4'hf;
      if (motor_on[dcr_r[1:0]])
        drive_select_n[dcr_r[1:0]] <= 1'b0; // [R11]
      filter_ground_high_rate <= (rate_r == `FHRI_RATE_500); // [R3]
      filter_ground_low_rate <= (rate_r == `FHRI_RATE_300) | (rate_r == `FHRI_RATE_250);
      spindle_speed_low_current <= (rate_r == `FHRI_RATE_500) |
        ((rate_r == `FHRI_RATE_1000) & ~drive_type_pin);
      precomp_sel <= pre_of(rate_r, drive_type_pin, precomp_mode_pin); // [R4]
      osc_on <= pwr_nxt != PWR_OFF; // [R6]
      core_reset <= ~dcr_r[`FHRI_DCR_SOFT_RST]; // [R14] [R23]
      int_out <= dma_en & core_int_req; // [R13]
      int_oe_n <= ~dma_en; // [R24]
      dma_request <= dma_en & core_dma_req;
      dma_request_oe_n <= ~dma_en;
      dma_ack_core <= dma_en & ~dma_acknowledge_n; // [R24]
      result_status_zero <= {res_term_code, res_low_bits}; // [R22]
    end
  end

endmodule

// >>> fhri_chk_sva.sv
// assertions on the fhri_top pins
// bound into every fhri_top instance, single mclk domain
`timescale 1ns/1ps
module fhri_chk (
  // clock and reset
  input wire mclk,
  input wire rst,
  // host bus
  input wire cs_n,
  input wire rd_n,
  input wire [2:0] addr,
  input wire [7:0] data_out,
  input wire [7:0] data_oe_n,
  // pins and control
  input wire disk_changed_input,
  input wire [3:0] motor_out_n,
  input wire [3:0] drive_select_n,
  input wire filter_ground_low_rate,
  input wire core_tick,
  input wire osc_on,
  input wire core_reset,
  input wire core_lp_now
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire rdx = !cs_n && !rd_n;
  a_one_sel: assert property ($onehot0(~drive_select_n) &&
    (~drive_select_n & motor_out_n) == 4'h0) else $error("drive select without its motor");
  a_tick_gap: assert property (core_tick |=> !core_tick [*2])
    else $error("core tick closer than three cycles");
  a_rst_vals: assert property (disable iff (1'b0)
    rst ##1 !rst |=> filter_ground_low_rate && core_reset) else $error("reset values wrong");
  a_bad_addr: assert property (rdx && addr inside {3'h0, 3'h1, 3'h3, 3'h6} ##1 rdx
    && $stable(addr) |-> data_oe_n == 8'hff) else $error("bus driven at unmapped address");
  a_dkc_bit: assert property (rdx && addr == 3'h7 && $stable(disk_changed_input) |=>
    data_oe_n == 8'h7f && data_out[7] == !$past(disk_changed_input)) else $error("bad dkc read");
  a_lp_enter: assert property (core_lp_now && osc_on && cs_n |=> !osc_on)
    else $error("low power not entered");
  a_wake_osc: assert property (!osc_on && rdx && addr == 3'h4 |=> osc_on)
    else $error("status read did not wake oscillator");
  a_no_tick: assert property (!osc_on && !$past(osc_on) |-> !core_tick)
    else $error("core tick while oscillator off");
endmodule

bind fhri_top fhri_chk chk (.mclk, .rst, .cs_n, .rd_n, .addr, .data_out, .data_oe_n,
  .disk_changed_input, .motor_out_n, .drive_select_n, .filter_ground_low_rate, .core_tick,
  .osc_on, .core_reset, .core_lp_now);

// >>> fhri_core_model.sv
// controller core stand-in: answers each data byte after a delay
// assumes it sees the core side strobes of fhri_top
`timescale 1ns/1ps
module fhri_core_model #(
  parameter DLY = 8
) (
  // clock and core reset
  input wire mclk,
  input wire core_reset,
  // transfer strobes
  input wire cmd_byte_strobe,
  input wire result_read_strobe,
  // ready pulse
  output reg core_byte_ready = 1'b0
);
  reg [7:0] cnt_r = 8'h00;
  always @(posedge mclk) begin
    if (core_reset || cmd_byte_strobe || result_read_strobe) begin
      cnt_r <= DLY;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
    core_byte_ready <= (cnt_r == 8'h01) && !core_reset;
  end
endmodule

// >>> fhri_top_tb_top.sv
// testbench for fhri_top with the core stand-in
// assumes short power timers and a 200 MHz mclk
`timescale 1ns/1ps
module fhri_top_tb_top;
  reg mclk = 1'b0, rst = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  reg [2:0] addr = 3'h0;
  reg [7:0] data_in = 8'h00, core_result_byte = 8'h5a;
  reg drive_type_pin = 1'b0, precomp_mode_pin = 1'b0, disk_changed_input = 1'b0;
  reg dma_acknowledge_n = 1'b0, core_int_req = 1'b1, core_dma_req = 1'b1;
  reg core_dir_read = 1'b0, core_exec_nondma = 1'b0, core_lp_auto_en = 1'b0, core_idle = 1'b0;
  reg [3:0] pv = 4'h0;
  reg [1:0] core_seek_drive = 2'h2, res_term_code = 2'h0;
  reg [5:0] res_low_bits = 6'h00;
  wire [7:0] data_out, data_oe_n, cmd_byte, result_status_zero;
  wire [3:0] motor_out_n, drive_select_n;
  wire [1:0] precomp_sel;
  wire int_out, int_oe_n, dma_request, dma_request_oe_n, filter_ground_high_rate;
  wire filter_ground_low_rate, spindle_speed_low_current, core_tick, osc_on, core_reset;
  wire core_byte_ready, cmd_byte_strobe, result_read_strobe, dma_ack_core;
  wire [7:0] ctl = {filter_ground_high_rate, filter_ground_low_rate, spindle_speed_low_current,
    core_reset, int_oe_n, dma_request_oe_n, precomp_sel};
  localparam [11:0] bad_addrs = 12'hcc8;
  integer n_errors = 0, total_checks = 0, cyc = 0, i;
  integer n_cmd = 0, n_res = 0;
  reg [7:0] d, o, n, e;

  fhri_top #(.AUTO_LP_CYCLES(50), .OSC_STAB_CYCLES(20)) dut (.mclk, .rst, .cs_n, .rd_n, .wr_n,
    .addr, .data_in, .data_out, .data_oe_n, .int_out, .int_oe_n, .dma_request,
    .dma_request_oe_n, .dma_acknowledge_n, .drive_type_pin, .precomp_mode_pin,
    .disk_changed_input, .motor_out_n, .drive_select_n, .filter_ground_high_rate,
    .filter_ground_low_rate, .spindle_speed_low_current, .core_tick, .precomp_sel, .osc_on,
    .core_reset, .core_byte_ready, .core_dir_read, .core_exec_nondma, .core_cmd_done(pv[1]),
    .core_seek_set(pv[2]), .core_seek_clr(pv[3]), .core_seek_drive, .core_result_byte,
    .core_int_req, .core_dma_req, .core_lp_now(pv[0]), .core_lp_auto_en, .core_idle,
    .res_term_code, .res_low_bits, .cmd_byte, .cmd_byte_strobe, .result_read_strobe,
    .dma_ack_core, .result_status_zero);
  fhri_core_model #(.DLY(8)) core (.mclk, .core_reset, .cmd_byte_strobe, .result_read_strobe,
    .core_byte_ready);

  initial forever #2.5 mclk = ~mclk;

  // count accepted data register transfers, strobes stand a full cycle
  always @(negedge mclk) begin
    n_cmd = n_cmd + cmd_byte_strobe;
    n_res = n_res + result_read_strobe;
  end

  task wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end

  task chk(input string nm, input [7:0] got, input [7:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task wr(input [2:0] a, input [7:0] v);
    @(negedge mclk);
    cs_n = 1'b0;
    wr_n = 1'b0;
    addr = a;
    data_in = v;
    @(negedge mclk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    repeat (2) @(negedge mclk);
  endtask
  task rd(input [2:0] a, output [7:0] v, output [7:0] oe);
    @(negedge mclk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    repeat (2) @(negedge mclk);
    v = data_out;
    oe = data_oe_n;
    cs_n = 1'b1;
    rd_n = 1'b1;
  endtask
  task msr(input [7:0] x);
    rd(3'h4, d, o);
    chk("msr", d, x);
    chk("msr_oe", o, 8'h00);
  endtask
  task pulse(input [3:0] m);
    @(negedge mclk);
    pv = m;
    @(negedge mclk);
    pv = 4'h0;
  endtask
  task ticks(output [7:0] c);
    c = 8'h00;
    repeat (30) begin
      @(negedge mclk);
      c = c + {7'h0, core_tick};
    end
  endtask
  // packs {fgh, fgl, speed, divide, precomp}
  function [7:0] rexp(input [1:0] c, input dt, input pn);
    if (c == 2'h0) rexp = 8'had;
    else if (c == 2'h3) rexp = {2'b00, !dt, 5'h0c};
    else if (c == 2'h1 && dt) rexp = 8'h56;
    else rexp = {6'h16, pn, 1'b1};
  endfunction

  initial begin
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    chk("rst_pins", {motor_out_n, drive_select_n}, 8'hff);
    chk("rst_ctl", ctl, 8'h5d);
    $display("end reset");
    for (i = 0; i < 16; i = i + 1) begin
      drive_type_pin = i[2];
      precomp_mode_pin = i[3];
      wr(3'h7, {6'h00, i[1:0]});
      repeat (6) @(negedge mclk);
      e = rexp(i[1:0], i[2], i[3]);
      chk("rate", ctl & 8'he3, e & 8'he3);
      ticks(n);
      chk("tick", n, 8'd30 / {5'h0, e[4:2]});
    end
    $display("end rate");
    for (i = 0; i < 4; i = i + 1) begin
      wr(3'h2, {~(4'h1 << i), 2'b01, i[1:0]});
      chk("sel_off", {motor_out_n, drive_select_n}, {4'h1 << i, 4'hf});
      wr(3'h2, {4'h1 << i, 2'b01, i[1:0]});
      chk("sel_on", {motor_out_n, drive_select_n}, {~(4'h1 << i), ~(4'h1 << i)});
    end
    wr(3'h2, 8'h0c);
    chk("dma_on", {4'h0, ctl[4:2], dma_ack_core}, 8'h01);
    chk("dma_pins_on", {6'h0, int_out, dma_request}, 8'h03);
    wr(3'h2, 8'h00);
    chk("dma_off", {4'h0, ctl[4:2], dma_ack_core}, 8'h0e);
    chk("dma_pins_off", {6'h0, int_out, dma_request}, 8'h00);
    chk("keep", ctl & 8'he3, 8'h00);
    wr(3'h5, 8'h33);
    chk("refused", cmd_byte, 8'h00);
    wr(3'h2, 8'h04);
    $display("end drive");
    repeat (16) @(negedge mclk);
    msr(8'h80);
    wr(3'h5, 8'h0f);
    chk("cmd", cmd_byte, 8'h0f);
    msr(8'h10);
    pulse(4'h4);
    repeat (10) @(negedge mclk);
    msr(8'h94);
    core_exec_nondma = 1'b1;
    core_dir_read = 1'b1;
    msr(8'hf4);
    rd(3'h5, d, o);
    chk("result", d, 8'h5a);
    msr(8'h74);
    core_exec_nondma = 1'b0;
    pulse(4'ha);
    repeat (10) @(negedge mclk);
    msr(8'hc0);
    for (i = 0; i < 4; i = i + 1) begin
      res_term_code = i[1:0];
      res_low_bits = {3{~i[1:0]}};
      repeat (2) @(negedge mclk);
      chk("res_zero", result_status_zero, {i[1:0], {3{~i[1:0]}}});
    end
    for (i = 0; i < 2; i = i + 1) begin
      disk_changed_input = i[0];
      repeat (2) @(negedge mclk);
      rd(3'h7, d, o);
      chk("dkc_oe", o, 8'h7f);
      chk("dkc", {7'h0, d[7]}, {7'h0, !i[0]});
    end
    for (i = 0; i < 4; i = i + 1) begin
      rd(bad_addrs[3 * i +: 3], d, o);
      chk("float", o, 8'hff);
    end
    $display("end status");
    wr(3'h2, 8'h14);
    pulse(4'h1);
    chk("lp", {osc_on, 3'h0, drive_select_n}, 8'h0e);
    ticks(n);
    chk("lp_tick", n, 8'h00);
    msr(8'h40);
    chk("wake", {7'h0, osc_on}, 8'h01);
    repeat (30) @(negedge mclk);
    msr(8'hc0);
    core_idle = 1'b1;
    core_lp_auto_en = 1'b1;
    repeat (70) @(negedge mclk);
    chk("auto_lp", {7'h0, osc_on}, 8'h00);
    chk("cmd_strobes", n_cmd[7:0], 8'h01);
    chk("res_strobes", n_res[7:0], 8'h01);
    $display("end power");
    wrap_up;
  end
endmodule
